// *** logic/hpc_counter.sv ***
// hpc_counter: mode-driven 24-bit high-speed pulse counter with register port
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - bad mode/preset/set: error flag, not run
// - one-phase modes count phase A only
// - one-phase direction from B or program bit
// - preset modes take external preset input
// - other modes take program preset bit
// - two-phase modes count from A and B
// - two-phase multiply x1, x2, x4 by code
// - enable off stops and clears count
// - preset request loads preset value
// - two-phase direction from A/B phase order
// - wrap flag on 24-bit over or underflow
module hpc_counter (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic preset_in,
    output logic irq,
    output logic instruction_error_flag,
    output logic wrap_flag,
    output logic count_ge_set,
    output logic running
);
    typedef struct packed {
        logic a_q;
        logic b_q;
        logic ctrl_en;
        logic ctrl_down;
        logic ctrl_preset;
        logic running;
        logic [31:0] pend_mode;
        logic [31:0] pend_preset;
        logic [31:0] pend_set;
        logic [15:0] mode;
        logic [23:0] preset_value;
        logic [23:0] set_value;
        logic [23:0] count;
        logic [2:0] status;
        logic [2:0] mask;
        logic ge;
        logic irq;
        logic [31:0] rdata;
    } hpc_state_t;

    hpc_state_t st_reg;
    hpc_state_t st_next;
    logic two_phase;
    logic ext_preset;
    logic preset_load;
    logic cnt_en;
    logic step;
    logic down;
    logic cmd_go;
    logic cmd_ok;
    logic [2:0] events;

    // ==========================================================
    // mode decode
    // validity of a staged mode word; cmd_ok adds the 24-bit field checks
    function automatic logic hpc_mode_ok(input logic [31:0] m);
        logic ok;
        ok = 1'b0;
        if (m[31:16] == 16'h0000) begin
            case (m[15:0])
                hpc_pkg::MODE_1P_PROG, hpc_pkg::MODE_1P_PRE,
                hpc_pkg::MODE_1P_B, hpc_pkg::MODE_1P_B_PRE,
                hpc_pkg::MODE_2P_X1, hpc_pkg::MODE_2P_X2,
                hpc_pkg::MODE_2P_X4, hpc_pkg::MODE_2P_X1_PRE,
                hpc_pkg::MODE_2P_X2_PRE, hpc_pkg::MODE_2P_X4_PRE: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction : hpc_mode_ok

    assign two_phase = st_reg.mode[hpc_pkg::MODE_TWO_PHASE_BIT];
    assign ext_preset = st_reg.mode[hpc_pkg::MODE_EXT_PRESET_BIT];
    // preset terminal is ignored unless the mode selects it
    assign preset_load = ext_preset ? preset_in : st_reg.ctrl_preset;
    // no counting until a valid instruction has been accepted
    assign cnt_en = st_reg.ctrl_en & st_reg.running;
    assign cmd_go = wr_en && (addr == hpc_pkg::OFS_CMD) && wr_data[hpc_pkg::CMD_GO_BIT];
    assign cmd_ok = hpc_mode_ok(st_reg.pend_mode)
        && (st_reg.pend_preset[31:24] == 8'h00)
        && (st_reg.pend_set[31:24] == 8'h00);

    // ==========================================================
    // edge decoder
    hpc_step_decode u_step (
        .a_prev(st_reg.a_q),
        .b_prev(st_reg.b_q),
        .a_now(phase_a),
        .b_now(phase_b),
        .two_phase(two_phase),
        .dir_from_b(st_reg.mode[hpc_pkg::MODE_DIR_B_BIT]),
        .prog_down(st_reg.ctrl_down),
        .mult(st_reg.mode[2:0]),
        .step(step),
        .down(down)
    );

    // ==========================================================
    // next-state logic
    always_comb begin
        st_next = st_reg;
        events = 3'h0;
        st_next.a_q = phase_a;
        st_next.b_q = phase_b;
        st_next.rdata = 32'h00000000;
        // register writes
        if (wr_en) begin
            case (addr)
                hpc_pkg::OFS_CTRL: begin
                    st_next.ctrl_en = wr_data[hpc_pkg::CTRL_EN_BIT];
                    st_next.ctrl_down = wr_data[hpc_pkg::CTRL_DOWN_BIT];
                    st_next.ctrl_preset = wr_data[hpc_pkg::CTRL_PRESET_BIT];
                end
                hpc_pkg::OFS_MODE: st_next.pend_mode = wr_data;
                hpc_pkg::OFS_PRESET: st_next.pend_preset = wr_data;
                hpc_pkg::OFS_SET: st_next.pend_set = wr_data;
                hpc_pkg::OFS_MASK: st_next.mask = wr_data[2:0];
                default: ;
            endcase
        end
        // instruction launch: a bad setting leaves the old config running
        if (cmd_go) begin
            if (cmd_ok) begin
                st_next.mode = st_reg.pend_mode[15:0];
                st_next.preset_value = st_reg.pend_preset[23:0];
                st_next.set_value = st_reg.pend_set[23:0];
                st_next.running = 1'b1;
            end else begin
                events[hpc_pkg::ST_ERR_BIT] = 1'b1;
            end
        end
        // count: clear beats preset, preset beats a pulse
        if (!cnt_en) begin
            st_next.count = 24'h000000;
        end else if (preset_load) begin
            st_next.count = st_reg.preset_value;
        end else if (step) begin
            if (down) begin
                st_next.count = st_reg.count - 24'h000001;
                events[hpc_pkg::ST_WRAP_BIT] = (st_reg.count == 24'h000000);
            end else begin
                st_next.count = st_reg.count + 24'h000001;
                events[hpc_pkg::ST_WRAP_BIT] = (st_reg.count == hpc_pkg::CNT_MAX);
            end
        end
        // reach compare lags the count by one cycle
        st_next.ge = cnt_en && (st_reg.count >= st_reg.set_value);
        events[hpc_pkg::ST_REACH_BIT] = st_next.ge & ~st_reg.ge;
        // sticky status: a new event wins over a same-cycle clear
        if (wr_en && addr == hpc_pkg::OFS_STATUS) begin
            st_next.status = (st_reg.status & ~wr_data[2:0]) | events;
        end else begin
            st_next.status = st_reg.status | events;
        end
        st_next.irq = |(st_next.status & st_next.mask);
        // register reads, answer in the following cycle
        if (rd_en) begin
            case (addr)
                hpc_pkg::OFS_CTRL: st_next.rdata = {29'h0, st_reg.ctrl_preset,
                                                    st_reg.ctrl_down, st_reg.ctrl_en};
                hpc_pkg::OFS_MODE: st_next.rdata = st_reg.pend_mode;
                hpc_pkg::OFS_PRESET: st_next.rdata = st_reg.pend_preset;
                hpc_pkg::OFS_SET: st_next.rdata = st_reg.pend_set;
                hpc_pkg::OFS_COUNT: st_next.rdata = {8'h00, st_reg.count};
                hpc_pkg::OFS_STATUS: st_next.rdata = {29'h0, st_reg.status};
                hpc_pkg::OFS_MASK: st_next.rdata = {29'h0, st_reg.mask};
                hpc_pkg::OFS_STATE: st_next.rdata = {st_reg.mode, 14'h0,
                                                     st_reg.ge, st_reg.running};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.mode <= hpc_pkg::MODE_RST;
            st_reg.pend_mode <= {16'h0000, hpc_pkg::MODE_RST};
            st_reg.mask <= hpc_pkg::MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign rd_data = st_reg.rdata;
    assign irq = st_reg.irq;
    assign instruction_error_flag = st_reg.status[hpc_pkg::ST_ERR_BIT];
    assign wrap_flag = st_reg.status[hpc_pkg::ST_WRAP_BIT];
    assign count_ge_set = st_reg.ge;
    assign running = st_reg.running;

    // ==========================================================
    // assertions: instruction launch, flags and counting
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // a good launch copies the staged word and starts the counter
    a_good_cmd_run: assert property (cmd_go && cmd_ok |=> running
        && {16'h0000, st_reg.mode} == $past(st_reg.pend_mode))
        else $error("valid instruction not executed");
    // a refused launch must not start a stopped counter
    a_bad_keeps_run: assert property (cmd_go && !cmd_ok
        |=> running == $past(running))
        else $error("bad instruction changed run state");
    // wrap is sticky until software writes a one to its bit
    a_wrap_sticky: assert property (wrap_flag
        && !(wr_en && addr == hpc_pkg::OFS_STATUS && wr_data[hpc_pkg::ST_WRAP_BIT])
        |=> wrap_flag)
        else $error("wrap flag dropped without a clear");
    a_wrap_down: assert property (cnt_en && !preset_load && step && down
        && st_reg.count == 24'h000000 |=> st_reg.count == hpc_pkg::CNT_MAX && wrap_flag)
        else $error("underflow did not wrap or flag");

    a_bad_cmd_error: assert property (cmd_go && !cmd_ok |=>
        instruction_error_flag && st_reg.mode == $past(st_reg.mode))
        else $error("bad instruction not flagged or executed");
    a_one_phase_a: assert property (cnt_en && !two_phase && !preset_load
        && !(phase_a && !st_reg.a_q) |=> st_reg.count == $past(st_reg.count))
        else $error("one-phase count moved without A rise");
    a_dir_from_b: assert property (cnt_en && !two_phase && !preset_load
        && st_reg.mode[hpc_pkg::MODE_DIR_B_BIT] && phase_a && !st_reg.a_q && phase_b
        |=> st_reg.count == $past(st_reg.count) - 24'h000001)
        else $error("B high did not count down");
    // compare with the old preset: a launch in the same cycle moves preset_value
    a_ext_preset: assert property (cnt_en && ext_preset && preset_in
        |=> st_reg.count == $past(st_reg.preset_value))
        else $error("external preset not loaded");
    a_prog_preset: assert property (cnt_en && !ext_preset && !st_reg.ctrl_preset
        && preset_in && !step |=> st_reg.count == $past(st_reg.count))
        else $error("preset terminal not ignored");
    a_x1_b_only: assert property (cnt_en && two_phase && !preset_load
        && st_reg.mode[2:0] == hpc_pkg::MULT_X1 && phase_a == st_reg.a_q
        |=> st_reg.count == $past(st_reg.count))
        else $error("x1 counted without A edge");
    a_quad_down: assert property (cnt_en && two_phase && !preset_load
        && st_reg.mode[2:0] != hpc_pkg::MULT_X1 && !phase_a && st_reg.a_q && !phase_b
        && !st_reg.b_q |=> st_reg.count == $past(st_reg.count) - 24'h000001)
        else $error("quadrature reverse did not count down");
    a_enable_clear: assert property (!cnt_en |=> st_reg.count == 24'h000000)
        else $error("count not cleared while disabled");
    a_wrap_up: assert property (cnt_en && !preset_load && step && !down
        && st_reg.count == hpc_pkg::CNT_MAX |=> st_reg.count == 24'h000000 && wrap_flag)
        else $error("overflow did not wrap or flag");
    // an unmasked refusal must reach the interrupt pin on the next edge
    a_irq_level: assert property (cmd_go && !cmd_ok
        && st_reg.mask[hpc_pkg::ST_ERR_BIT] |=> irq)
        else $error("masked-in error raised no interrupt");

    // ==========================================================
    // assertions: counting paths
    // the preset request is a level and reloads on every cycle it stands
    a_preset_load: assert property (cnt_en && preset_load
        |=> st_reg.count == $past(st_reg.preset_value))
        else $error("preset request did not load");
    // one-phase modes take at most a direction level from B, never a step
    a_b_ignored: assert property (cnt_en && !two_phase && !preset_load
        && phase_a == st_reg.a_q && phase_b != st_reg.b_q
        |=> st_reg.count == $past(st_reg.count))
        else $error("one-phase count moved on a B edge");
    a_one_phase_up: assert property (cnt_en && !two_phase && !preset_load
        && !st_reg.mode[hpc_pkg::MODE_DIR_B_BIT] && !st_reg.ctrl_down
        && phase_a && !st_reg.a_q
        |=> st_reg.count == $past(st_reg.count) + 24'h000001)
        else $error("program direction up did not count up");
    // B already high when A rises means the encoder turns backwards
    a_x1_down: assert property (cnt_en && two_phase && !preset_load
        && st_reg.mode[2:0] == hpc_pkg::MULT_X1 && phase_a && !st_reg.a_q && phase_b
        |=> st_reg.count == $past(st_reg.count) - 24'h000001)
        else $error("x1 with B leading did not count down");
    // x2 and x4 must move on edges that x1 ignores
    a_x2_a_fall: assert property (cnt_en && two_phase && !preset_load
        && st_reg.mode[2:0] == hpc_pkg::MULT_X2 && !phase_a && st_reg.a_q
        |=> st_reg.count != $past(st_reg.count))
        else $error("x2 missed a falling A edge");
    a_x4_b_edge: assert property (cnt_en && two_phase && !preset_load
        && st_reg.mode[2:0] == hpc_pkg::MULT_X4 && phase_a == st_reg.a_q
        && phase_b != st_reg.b_q |=> st_reg.count != $past(st_reg.count))
        else $error("x4 missed a B edge");

    // ==========================================================
    // cover points
    // main scenarios the bench is meant to reach
    c_wrap_seen: cover property (cnt_en ##1 wrap_flag);
    c_x4_count: cover property (two_phase && st_reg.mode[2:0] == hpc_pkg::MULT_X4 && step);
    c_bad_cmd: cover property (cmd_go && !cmd_ok);
    c_reach: cover property (!count_ge_set ##1 count_ge_set);
    c_ext_preset: cover property (cnt_en && ext_preset && preset_in);
endmodule : hpc_counter
`default_nettype wire

// *** logic/hpc_pkg.sv ***
// hpc_pkg: shared constants of the high-speed pulse counter
package hpc_pkg;
    // ==========================================================
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 24;
    localparam logic [23:0] CNT_MAX = 24'hFFFFFF;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_PRESET = 8'h08;
    localparam logic [7:0] OFS_SET = 8'h0C;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_MASK = 8'h1C;
    localparam logic [7:0] OFS_STATE = 8'h20;

    // ==========================================================
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DOWN_BIT = 1;
    localparam int CTRL_PRESET_BIT = 2;
    localparam int CMD_GO_BIT = 0;
    localparam int ST_WRAP_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_REACH_BIT = 2;
    localparam int MODE_EXT_PRESET_BIT = 4;
    localparam int MODE_DIR_B_BIT = 8;
    localparam int MODE_TWO_PHASE_BIT = 13;

    // ==========================================================
    // counter mode words
    localparam logic [15:0] MODE_1P_PROG = 16'h1000;
    localparam logic [15:0] MODE_1P_PRE = 16'h1010;
    localparam logic [15:0] MODE_1P_B = 16'h1100;
    localparam logic [15:0] MODE_1P_B_PRE = 16'h1110;
    localparam logic [15:0] MODE_2P_X1 = 16'h2001;
    localparam logic [15:0] MODE_2P_X2 = 16'h2002;
    localparam logic [15:0] MODE_2P_X4 = 16'h2004;
    localparam logic [15:0] MODE_2P_X1_PRE = 16'h2011;
    localparam logic [15:0] MODE_2P_X2_PRE = 16'h2012;
    localparam logic [15:0] MODE_2P_X4_PRE = 16'h2014;
    localparam logic [2:0] MULT_X1 = 3'h1;
    localparam logic [2:0] MULT_X2 = 3'h2;
    localparam logic [2:0] MULT_X4 = 3'h4;

    // ==========================================================
    // reset values
    localparam logic [15:0] MODE_RST = 16'h1000;
    localparam logic [2:0] MASK_RST = 3'h0;
endpackage : hpc_pkg

// *** logic/hpc_step_decode.sv ***
// hpc_step_decode: turns phase A/B edges into a count step and direction
`timescale 1ns/100ps
`default_nettype none
module hpc_step_decode (
    input wire logic a_prev,
    input wire logic b_prev,
    input wire logic a_now,
    input wire logic b_now,
    input wire logic two_phase,
    input wire logic dir_from_b,
    input wire logic prog_down,
    input wire logic [2:0] mult,
    output logic step,
    output logic down
);
    logic a_rise;
    logic a_edge;
    logic b_edge;

    // ==========================================================
    // edge detection against last sampled level
    assign a_rise = a_now & ~a_prev;
    assign a_edge = a_now ^ a_prev;
    assign b_edge = b_now ^ b_prev;

    // ==========================================================
    // step and direction selection
    always_comb begin
        step = 1'b0;
        down = 1'b0;
        if (!two_phase) begin
            step = a_rise; // pulses only on phase A
            down = dir_from_b ? b_now : prog_down; // B high means down
        end else begin
            case (mult) // multiplication by mode
                hpc_pkg::MULT_X1: begin
                    step = a_rise;
                    down = b_now; // B already high: B leads
                end
                hpc_pkg::MULT_X2: begin
                    step = a_edge;
                    down = ~(a_now ^ b_now);
                end
                hpc_pkg::MULT_X4: begin
                    // both phases moving at once is not quadrature; drop it
                    if (a_edge && !b_edge) begin
                        step = 1'b1;
                        down = ~(a_now ^ b_now);
                    end else if (b_edge && !a_edge) begin
                        step = 1'b1;
                        down = a_now ^ b_now;
                    end
                end
                default: begin
                    step = 1'b0;
                end
            endcase
        end
    end
endmodule : hpc_step_decode
`default_nettype wire

// *** verification/hpc_counter_tb.sv ***
// hpc_counter_tb: self-checking bench for the high-speed pulse counter
`timescale 1ns/100ps
`default_nettype none
module hpc_counter_tb;
    // ==========================================================
    // signals and bookkeeping
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic preset_in = 1'b0;
    logic [31:0] rd_data;
    logic phase_a, phase_b, irq, err_flag, wrap, ge, running;
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'hc1e4;
    logic [31:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic [15:0] modes[10] = '{hpc_pkg::MODE_1P_PROG, hpc_pkg::MODE_1P_PRE,
        hpc_pkg::MODE_1P_B, hpc_pkg::MODE_1P_B_PRE, hpc_pkg::MODE_2P_X1, hpc_pkg::MODE_2P_X2,
        hpc_pkg::MODE_2P_X4, hpc_pkg::MODE_2P_X1_PRE, hpc_pkg::MODE_2P_X2_PRE,
        hpc_pkg::MODE_2P_X4_PRE};
    logic [31:0] bad_mode[4] = '{32'h00001234, 32'h00011000, 32'h00001000, 32'h00002004};
    logic [31:0] bad_set[4] = '{32'h00000000, 32'h00000000, 32'h01000000, 32'h00000000};
    logic [31:0] bad_pre[4] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h80000000};

    always #4 clk_sys = ~clk_sys;

    hpc_counter uut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .phase_a(phase_a),
        .phase_b(phase_b), .preset_in(preset_in), .irq(irq),
        .instruction_error_flag(err_flag), .wrap_flag(wrap), .count_ge_set(ge),
        .running(running));
    hpc_encoder_model enc (.clk_sys(clk_sys), .phase_a(phase_a), .phase_b(phase_b));

    // ==========================================================
    // comparison and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // an idle edge after each strobe keeps two drives of a strobe out of one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        @(posedge clk_sys);
    endtask : rd

    // read answers stand only one cycle after the strobe: match each to the oldest note
    always @(posedge clk_sys) begin
        if (rd_pend) begin
            check(rd_data, exp_q.pop_front());
        end
        rd_pend <= rd_en;
    end

    task automatic tally_and_finish;
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // scenarios
    initial begin : main
        logic [15:0] m;
        logic two, ext, dn, rev, down, wrapx;
        logic [31:0] pv, s, kn, ctl, cnt;
        int n, h;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        // reset state, and an unmapped place that ignores writes
        rd(hpc_pkg::OFS_COUNT, 32'h0);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        // bad words: error raised, nothing launched, irq only once masked in
        for (int i = 0; i < 4; i++) begin
            wr(hpc_pkg::OFS_MODE, bad_mode[i]);
            wr(hpc_pkg::OFS_PRESET, bad_pre[i]);
            wr(hpc_pkg::OFS_SET, bad_set[i]);
            wr(hpc_pkg::OFS_CMD, 32'h1);
            check(err_flag, 1'b1);
            check(irq | running, 1'b0);
            rd(hpc_pkg::OFS_STATE, 32'h10000000);
            wr(hpc_pkg::OFS_MASK, 32'h2);
            check(irq, 1'b1);
            wr(hpc_pkg::OFS_STATUS, 32'h2);
            wr(hpc_pkg::OFS_MASK, 32'h1);
            check(err_flag | irq, 1'b0);
        end
        // every mode: preset source, clear on disable, then counting from the external preset in preset modes, from zero in the others
        foreach (modes[i]) begin
            m = modes[i];
            two = m[hpc_pkg::MODE_TWO_PHASE_BIT];
            ext = m[hpc_pkg::MODE_EXT_PRESET_BIT];
            pv = $random(seed) & 32'h00FFFFFF;
            if (pv[0]) pv = 32'h00FFFFFE;
            rev = 1'($random(seed));
            dn = 1'($random(seed));
            n = 1 + ($random(seed) & 3);
            h = 1 + ($random(seed) & 1) * 2;
            kn = n * (two ? int'(m[2:0]) : 1);
            down = (two || m[hpc_pkg::MODE_DIR_B_BIT]) ? rev : dn;
            ctl = {30'h0, dn, 1'b1};
            wr(hpc_pkg::OFS_CTRL, 32'h0);
            wr(hpc_pkg::OFS_MODE, {16'h0000, m});
            wr(hpc_pkg::OFS_PRESET, pv);
            wr(hpc_pkg::OFS_SET, 32'h00FFFFFF);
            wr(hpc_pkg::OFS_CMD, 32'h1);
            wr(hpc_pkg::OFS_CTRL, ctl | 32'h4);
            wr(hpc_pkg::OFS_CTRL, ctl);
            rd(hpc_pkg::OFS_COUNT, ext ? 32'h0 : pv);
            wr(hpc_pkg::OFS_CTRL, 32'h0);
            rd(hpc_pkg::OFS_COUNT, 32'h0);
            check(ge, 1'b0);
            wr(hpc_pkg::OFS_CTRL, ctl);
            preset_in <= 1'b1;
            @(posedge clk_sys);
            preset_in <= 1'b0;
            s = ext ? pv : 32'h0;
            wr(hpc_pkg::OFS_STATUS, 32'h7);
            rd(hpc_pkg::OFS_COUNT, s);
            enc.run(n, rev, two, h);
            repeat (3) @(posedge clk_sys);
            wrapx = down ? (kn > s) : (s + kn > 32'h00FFFFFF);
            cnt = (down ? s - kn : s + kn) & 32'h00FFFFFF;
            rd(hpc_pkg::OFS_COUNT, cnt);
            rd(hpc_pkg::OFS_STATE, {m, 14'h0, cnt == 32'h00FFFFFF, 1'b1});
            check(wrap, wrapx);
            check(irq, wrapx);
        end
        repeat (4) @(posedge clk_sys);
        tally_and_finish();
    end

    // watchdog: the sequence needs at most some 900 cycles, so 25,000 means a hang
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : hpc_counter_tb
`default_nettype wire

// *** verification/hpc_encoder_model.sv ***
// hpc_encoder_model: pulse generator and quadrature encoder driving the counter inputs
`timescale 1ns/100ps
`default_nettype none
module hpc_encoder_model (
    input wire logic clk_sys,
    output logic phase_a,
    output logic phase_b
);
    // ==========================================================
    // idle levels
    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
    end

    // ==========================================================
    // waveform generation
    // n full periods of four steps; each step held h clocks, each phase level 2h, so h=1 is the fastest the counter accepts
    task automatic run(input int n, input logic rev, input logic two, input int h);
        // one-phase: direction level settles before the first A rise
        if (!two) begin
            phase_b <= rev;
            repeat (h) @(posedge clk_sys);
        end
        for (int i = 0; i < 4 * n; i++) begin
            if (!two) begin
                phase_a <= (i % 4) < 2;
            end else if (!rev) begin
                {phase_a, phase_b} <= {~phase_b, phase_a};
            end else begin
                {phase_a, phase_b} <= {phase_b, ~phase_a};
            end
            repeat (h) @(posedge clk_sys);
        end
    endtask : run
endmodule : hpc_encoder_model
`default_nettype wire
